// ### apm_pkg.sv
// Shared constants, timing figures and state types of the converter power-mode link.
package apm_pkg;

    // ======================================================================
    // Frame geometry
    // ======================================================================
    localparam int unsigned RESULT_W = 14;
    localparam int unsigned FRAME_W  = 32;
    localparam int unsigned CNT_W    = 6;

    localparam logic [CNT_W-1:0] EDGE_GLITCH = 6'h02;
    localparam logic [CNT_W-1:0] EDGE_AWAKE  = 6'h0A;
    localparam logic [CNT_W-1:0] EDGE_CONV   = 6'h10;
    localparam logic [CNT_W-1:0] EDGE_DUAL   = 6'h20;
    localparam logic [CNT_W-1:0] EDGE_MAX    = 6'h3F;
    localparam logic [CNT_W-1:0] EDGE_ONE    = 6'h01;

    // ======================================================================
    // Power states
    // ======================================================================
    typedef enum logic [1:0] {
        PWR_NORMAL  = 2'b00,
        PWR_PARTIAL = 2'b01,
        PWR_FULL    = 2'b10
    } apm_power_t;

    localparam apm_power_t RESET_POWER = PWR_NORMAL;

    // ======================================================================
    // Timing
    // ======================================================================
    localparam int unsigned LINK_PERIOD_NS          = 125;
    localparam int unsigned PART_WAKE_TIME_NS       = 200;
    localparam int unsigned PART_WAKE_CYCLES        = (PART_WAKE_TIME_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int unsigned WAKE_W                  = 2;

    localparam int unsigned CLK_PERIOD_NS           = 50;
    localparam int unsigned BUS_IDLE_GAP_TIME_NS    = 100;
    localparam int unsigned BUS_IDLE_GAP_CYCLES     = (BUS_IDLE_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DEEP_SLEEP_WAKE_TIME_US = 6000;
    localparam int unsigned DEEP_SLEEP_WAKE_CYCLES  =
        (DEEP_SLEEP_WAKE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Serial clock is made by dividing clk; one link period is SCLK_PHASES clk cycles.
    localparam int unsigned PHASE_W        = 3;
    localparam logic [PHASE_W-1:0] PHASE_RISE   = 3'h3;
    localparam logic [PHASE_W-1:0] PHASE_SAMPLE = 3'h5;
    localparam logic [PHASE_W-1:0] PHASE_FALL   = 3'h7;
    localparam int unsigned SCLK_PHASES    = 8;
    localparam int unsigned LINK_LAG_EDGES = 3;
    localparam logic [CNT_W-1:0] RX_FIRST_EDGE = 6'h03;
    localparam logic [CNT_W-1:0] RX_LAST_EDGE  = 6'h22;
    localparam int unsigned GAP_W          = 17;
    localparam int unsigned GAP_CYCLES     = LINK_LAG_EDGES * SCLK_PHASES + BUS_IDLE_GAP_CYCLES;

    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_ARM  = 2'b01,
        HST_LOW  = 2'b10,
        HST_GAP  = 2'b11
    } apm_host_state_t;

endpackage

// ### apm_link_if.sv
// Serial link between the converter end and the host end.
`timescale 1ns/10ps

interface apm_link_if;
    logic sclk;
    logic cs_n;
    logic sd_first;
    logic sd_first_oe;
    logic sd_second;
    logic sd_second_oe;
    logic first_line;
    logic second_line;

    // A released line reads low at the host.
    assign first_line  = sd_first_oe ? sd_first : 1'b0;
    assign second_line = sd_second_oe ? sd_second : 1'b0;

    modport dev (
        input  sclk,
        input  cs_n,
        output sd_first,
        output sd_first_oe,
        output sd_second,
        output sd_second_oe
    );

    modport host (
        output sclk,
        output cs_n,
        input  first_line,
        input  second_line
    );
endinterface

// ### apm_dev_end.sv
// Converter end: frame counting, power-mode selection and serial result output.
//
// Notes on behaviour
// [R01] Host holds select low ten edges for normal.
// [R02] Rise between edges ten and sixteen aborts, releases.
// [R03] Sixteen cycles convert; lines drive until rise.
// [R04] Two more cycles give two trailing zeros.
// [R05] Sixteen more cycles give the other result.
// [R06] Line released at edge thirty-two or rise.
// [R07] Host waits idle gap before next select fall.
// [R08] Normal, rise at edges two to nine: partial.
// [R09] Normal, rise before edge two: stay normal.
// [R10] Partial sleep keeps only reference powered.
// [R11] Dummy frame past edge ten wakes partial sleep.
// [R12] Partial, rise before edge two: stay partial.
// [R13] Partial, rise at edges two to nine: full.
// [R14] Full sleep switches off reference too.
// [R15] Sleep entry depends only on rise position.
// [R16] Host waits deep wake time after dummy frame.
// [R17] Partial wake: hold until first edge, then track.
// [R18] Power-on state arbitrary; one dummy frame first.
// [R19] Host uses short frames to reach sleep.
// [R20] Select fall samples inputs, starts, enables outputs.
// [R21] Edge counter clears at fall, judged at rise.
`timescale 1ns/10ps

module apm_dev_end (
    apm_link_if.dev                         link,
    input  wire logic                       reset,
    input  wire logic                       clk_en,
    input  wire logic [apm_pkg::RESULT_W-1:0] sample_first,
    input  wire logic [apm_pkg::RESULT_W-1:0] sample_second,
    output apm_pkg::apm_power_t             power_state,
    output logic                            ref_on,
    output logic                            analog_on,
    output logic                            analog_ready,
    output logic                            th_hold,
    output logic                            conv_done
);

    // ======================================================================
    // Select synchroniser
    // ======================================================================
    // Select comes from the host's clock, so it crosses two link-clock flops.
    // The edge count is therefore delayed by two periods but not shortened,
    // because rise and fall are delayed alike.
    logic cs_meta;
    logic cs_sync;

    always_ff @(negedge link.sclk or posedge reset) begin
        if (reset) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
        end else if (clk_en) begin
            cs_meta <= link.cs_n;
            cs_sync <= cs_meta;
        end
    end

    // ======================================================================
    // Frame state
    // ======================================================================
    logic                             in_frame;
    logic [apm_pkg::CNT_W-1:0]        count;
    logic                             drive;
    logic [apm_pkg::FRAME_W-1:0]      shift_first;
    logic [apm_pkg::FRAME_W-1:0]      shift_second;
    logic [apm_pkg::RESULT_W-1:0]     pend_first;
    logic [apm_pkg::RESULT_W-1:0]     pend_second;
    logic [apm_pkg::RESULT_W-1:0]     res_first;
    logic [apm_pkg::RESULT_W-1:0]     res_second;
    apm_pkg::apm_power_t              state;
    logic                             wake_partial;
    logic                             hold;
    logic                             done;
    logic                             ana;
    logic                             refp;
    logic [apm_pkg::WAKE_W-1:0]       wake_cnt;

    logic                             next_in_frame;
    logic [apm_pkg::CNT_W-1:0]        next_count;
    logic                             next_drive;
    logic [apm_pkg::FRAME_W-1:0]      next_shift_first;
    logic [apm_pkg::FRAME_W-1:0]      next_shift_second;
    logic [apm_pkg::RESULT_W-1:0]     next_pend_first;
    logic [apm_pkg::RESULT_W-1:0]     next_pend_second;
    logic [apm_pkg::RESULT_W-1:0]     next_res_first;
    logic [apm_pkg::RESULT_W-1:0]     next_res_second;
    apm_pkg::apm_power_t              next_state;
    logic                             next_wake_partial;
    logic                             next_hold;
    logic                             next_done;
    logic                             next_ana;
    logic                             next_refp;
    logic [apm_pkg::WAKE_W-1:0]       next_wake_cnt;

    logic                             cs_low;

    // Power state chosen from where select rose, given the edges seen.
    function automatic apm_pkg::apm_power_t pick_state(input apm_pkg::apm_power_t cur,
                                                      input logic [apm_pkg::CNT_W-1:0] edges);
        apm_pkg::apm_power_t r;
        r = cur;
        if (edges < apm_pkg::EDGE_GLITCH) begin
            r = cur;                                               // [R09] [R12]
        end else if (edges < apm_pkg::EDGE_AWAKE) begin
            unique case (cur)
                apm_pkg::PWR_NORMAL:  r = apm_pkg::PWR_PARTIAL;    // [R08]
                apm_pkg::PWR_PARTIAL: r = apm_pkg::PWR_FULL;       // [R13]
                apm_pkg::PWR_FULL:    r = apm_pkg::PWR_FULL;
                default:              r = apm_pkg::PWR_FULL;
            endcase
        end else begin
            r = apm_pkg::PWR_NORMAL;                               // [R02] [R11]
        end
        return r;
    endfunction

    always_comb begin
        cs_low            = ~cs_sync;
        next_in_frame     = in_frame;
        next_count        = count;
        next_drive        = drive;
        next_shift_first  = shift_first;
        next_shift_second = shift_second;
        next_pend_first   = pend_first;
        next_pend_second  = pend_second;
        next_res_first    = res_first;
        next_res_second   = res_second;
        next_state        = state;
        next_wake_partial = wake_partial;
        next_hold         = hold;
        next_done         = 1'b0;

        if (cs_low && !in_frame) begin
            // Fall: sample both inputs, start converting, drive the lines.
            next_in_frame     = 1'b1;                               // [R21]
            next_count        = apm_pkg::EDGE_ONE;                  // [R21]
            next_drive        = 1'b1;                               // [R20]
            next_pend_first   = sample_first;                       // [R20]
            next_pend_second  = sample_second;
            // Each line carries the previous results, its own first.
            next_shift_first  = {2'b00, res_first, 2'b00, res_second};   // [R04] [R05]
            next_shift_second = {2'b00, res_second, 2'b00, res_first};   // [R05]
            next_hold         = 1'b1;
            next_wake_partial = (state == apm_pkg::PWR_PARTIAL);
        end else if (cs_low && in_frame) begin
            if (count != apm_pkg::EDGE_MAX) begin
                next_count = count + apm_pkg::EDGE_ONE;
            end
            next_shift_first  = {shift_first[apm_pkg::FRAME_W-2:0], 1'b0};
            next_shift_second = {shift_second[apm_pkg::FRAME_W-2:0], 1'b0};
            if (count == apm_pkg::EDGE_DUAL) begin
                next_drive = 1'b0;                                  // [R06]
            end
            if (next_count == apm_pkg::EDGE_CONV) begin
                // Conversion complete; lines keep driving past this point.
                next_res_first  = pend_first;                       // [R03]
                next_res_second = pend_second;
                next_done       = 1'b1;
                next_hold       = 1'b0;
            end
            if (wake_partial && count == apm_pkg::EDGE_ONE) begin
                next_hold = 1'b0;                                   // [R17]
            end
        end else if (!cs_low && in_frame) begin
            // Rise: abort any unfinished conversion and release the lines.
            next_in_frame = 1'b0;
            next_drive    = 1'b0;                                   // [R02] [R03] [R06]
            next_count    = '0;
            next_state    = pick_state(state, count);               // [R15] [R21]
            next_hold     = (next_state != apm_pkg::PWR_NORMAL);
        end else begin
            next_hold = (state != apm_pkg::PWR_NORMAL);
        end

        // Analog power follows the state, and comes up for the whole frame.
        next_ana  = (next_state == apm_pkg::PWR_NORMAL) || next_in_frame;  // [R10] [R11] [R12]
        next_refp = (next_state != apm_pkg::PWR_FULL) || next_in_frame;    // [R14]

        if (!next_ana) begin
            next_wake_cnt = '0;
        end else if (wake_cnt != apm_pkg::WAKE_W'(apm_pkg::PART_WAKE_CYCLES)) begin
            next_wake_cnt = wake_cnt + 2'b01;                       // [R11]
        end else begin
            next_wake_cnt = wake_cnt;
        end
    end

    always_ff @(negedge link.sclk or posedge reset) begin
        if (reset) begin
            in_frame     <= 1'b0;
            count        <= '0;
            drive        <= 1'b0;
            shift_first  <= '0;
            shift_second <= '0;
            pend_first   <= '0;
            pend_second  <= '0;
            res_first    <= '0;
            res_second   <= '0;
            state        <= apm_pkg::RESET_POWER;                   // [R18]
            wake_partial <= 1'b0;
            hold         <= 1'b0;
            done         <= 1'b0;
            ana          <= 1'b1;
            refp         <= 1'b1;
            wake_cnt     <= '0;
        end else if (clk_en) begin
            in_frame     <= next_in_frame;
            count        <= next_count;
            drive        <= next_drive;
            shift_first  <= next_shift_first;
            shift_second <= next_shift_second;
            pend_first   <= next_pend_first;
            pend_second  <= next_pend_second;
            res_first    <= next_res_first;
            res_second   <= next_res_second;
            state        <= next_state;
            wake_partial <= next_wake_partial;
            hold         <= next_hold;
            done         <= next_done;
            ana          <= next_ana;
            refp         <= next_refp;
            wake_cnt     <= next_wake_cnt;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign link.sd_first     = shift_first[apm_pkg::FRAME_W-1];
    assign link.sd_second    = shift_second[apm_pkg::FRAME_W-1];
    assign link.sd_first_oe  = drive;
    assign link.sd_second_oe = drive;

    assign power_state  = state;
    assign ref_on       = refp;
    assign analog_on    = ana;
    // Readiness only tracks the short wake; a wake from full sleep is slower
    // and is left to the host to time.
    assign analog_ready = ana && (wake_cnt == apm_pkg::WAKE_W'(apm_pkg::PART_WAKE_CYCLES));
    assign th_hold      = hold;
    assign conv_done    = done;

endmodule

// ### apm_host_end.sv
// Host end: serial clock divider, select framing, result capture and wait times.
`timescale 1ns/10ps

module apm_host_end #(
    parameter int unsigned WAKE_CYCLES = apm_pkg::DEEP_SLEEP_WAKE_CYCLES
) (
    apm_link_if.host                       link,
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      clk_en,
    input  wire logic                      cmd_valid,
    output logic                           cmd_ready,
    input  wire logic [apm_pkg::CNT_W-1:0] cmd_edges,
    input  wire logic                      cmd_long_wait,
    output logic                           rsp_valid,
    output logic [apm_pkg::FRAME_W-1:0]    rsp_first,
    output logic [apm_pkg::FRAME_W-1:0]    rsp_second
);

    // ======================================================================
    // Line synchronisers
    // ======================================================================
    logic first_meta;
    logic first_sync;
    logic second_meta;
    logic second_sync;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            first_meta  <= 1'b0;
            first_sync  <= 1'b0;
            second_meta <= 1'b0;
            second_sync <= 1'b0;
        end else if (clk_en) begin
            first_meta  <= link.first_line;
            first_sync  <= first_meta;
            second_meta <= link.second_line;
            second_sync <= second_meta;
        end
    end

    // ======================================================================
    // Divider and framing
    // ======================================================================
    logic [apm_pkg::PHASE_W-1:0]  phase;
    logic                         sclk;
    logic                         cs_n;
    apm_pkg::apm_host_state_t     state;
    logic [apm_pkg::CNT_W-1:0]    fe;
    logic [apm_pkg::CNT_W-1:0]    target;
    logic                         long_wait;
    logic [apm_pkg::GAP_W-1:0]    gap;
    logic [apm_pkg::FRAME_W-1:0]  rx_first;
    logic [apm_pkg::FRAME_W-1:0]  rx_second;
    logic                         rsp;
    logic [apm_pkg::FRAME_W-1:0]  out_first;
    logic [apm_pkg::FRAME_W-1:0]  out_second;

    logic [apm_pkg::PHASE_W-1:0]  next_phase;
    logic                         next_sclk;
    logic                         next_cs_n;
    apm_pkg::apm_host_state_t     next_state;
    logic [apm_pkg::CNT_W-1:0]    next_fe;
    logic [apm_pkg::CNT_W-1:0]    next_target;
    logic                         next_long_wait;
    logic [apm_pkg::GAP_W-1:0]    next_gap;
    logic [apm_pkg::FRAME_W-1:0]  next_rx_first;
    logic [apm_pkg::FRAME_W-1:0]  next_rx_second;
    logic                         next_rsp;
    logic [apm_pkg::FRAME_W-1:0]  next_out_first;
    logic [apm_pkg::FRAME_W-1:0]  next_out_second;

    always_comb begin
        next_phase      = phase + 3'h1;
        next_sclk       = next_phase[apm_pkg::PHASE_W-1];
        next_cs_n       = cs_n;
        next_state      = state;
        next_fe         = fe;
        next_target     = target;
        next_long_wait  = long_wait;
        next_gap        = gap;
        next_rx_first   = rx_first;
        next_rx_second  = rx_second;
        next_rsp        = 1'b0;
        next_out_first  = out_first;
        next_out_second = out_second;

        unique case (state)
            apm_pkg::HST_IDLE: begin
                if (cmd_valid) begin
                    // Short counts give the interrupted cycles that reach sleep.
                    next_target    = cmd_edges;                     // [R19]
                    next_long_wait = cmd_long_wait;
                    next_state     = apm_pkg::HST_ARM;
                end
            end
            apm_pkg::HST_ARM: begin
                if (phase == apm_pkg::PHASE_RISE) begin
                    next_cs_n      = 1'b0;
                    next_fe        = '0;
                    next_rx_first  = '0;
                    next_rx_second = '0;
                    next_state     = apm_pkg::HST_LOW;
                end
            end
            apm_pkg::HST_LOW: begin
                if (phase == apm_pkg::PHASE_FALL && fe != apm_pkg::EDGE_MAX) begin
                    next_fe = fe + apm_pkg::EDGE_ONE;
                end
                if (phase == apm_pkg::PHASE_SAMPLE && fe >= apm_pkg::RX_FIRST_EDGE
                    && fe <= apm_pkg::RX_LAST_EDGE) begin
                    next_rx_first  = {rx_first[apm_pkg::FRAME_W-2:0], first_sync};
                    next_rx_second = {rx_second[apm_pkg::FRAME_W-2:0], second_sync};
                end
                if (phase == apm_pkg::PHASE_RISE && fe >= target) begin
                    // Select held low for the commanded number of falling edges.
                    next_cs_n  = 1'b1;                              // [R01] [R15]
                    next_state = apm_pkg::HST_GAP;
                    if (long_wait) begin
                        next_gap = apm_pkg::GAP_W'(WAKE_CYCLES);     // [R16]
                    end else begin
                        next_gap = apm_pkg::GAP_W'(apm_pkg::GAP_CYCLES);  // [R07]
                    end
                end
            end
            apm_pkg::HST_GAP: begin
                if (gap == '0) begin
                    next_rsp        = 1'b1;
                    next_out_first  = rx_first;
                    next_out_second = rx_second;
                    next_state      = apm_pkg::HST_IDLE;
                end else begin
                    next_gap = gap - 17'h0_0001;                    // [R07]
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase      <= '0;
            sclk       <= 1'b0;
            cs_n       <= 1'b1;
            state      <= apm_pkg::HST_IDLE;
            fe         <= '0;
            target     <= '0;
            long_wait  <= 1'b0;
            gap        <= '0;
            rx_first   <= '0;
            rx_second  <= '0;
            rsp        <= 1'b0;
            out_first  <= '0;
            out_second <= '0;
        end else if (clk_en) begin
            phase      <= next_phase;
            sclk       <= next_sclk;
            cs_n       <= next_cs_n;
            state      <= next_state;
            fe         <= next_fe;
            target     <= next_target;
            long_wait  <= next_long_wait;
            gap        <= next_gap;
            rx_first   <= next_rx_first;
            rx_second  <= next_rx_second;
            rsp        <= next_rsp;
            out_first  <= next_out_first;
            out_second <= next_out_second;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign link.sclk  = sclk;
    assign link.cs_n  = cs_n;
    assign cmd_ready  = (state == apm_pkg::HST_IDLE);
    assign rsp_valid  = rsp;
    assign rsp_first  = out_first;
    assign rsp_second = out_second;

endmodule

// ### apm_link_sva.sv
// Assertions on the serial link between the two ends.
`timescale 1ns/10ps
module apm_link_sva (
    input wire logic sclk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sd_first,
    input wire logic sd_first_oe,
    input wire logic sd_second,
    input wire logic sd_second_oe
);
    // ==================================================
    // Index of the bit on the lines, counted from the edge that enabled them.
    logic [5:0] run;
    logic [5:0] next_run;
    always_comb next_run = sd_first_oe ? run + 6'h01 : 6'h00;
    always_ff @(negedge sclk or posedge reset) begin
        if (reset) run <= 6'h00;
        else run <= next_run;
    end
    default clocking @(negedge sclk); endclocking
    default disable iff (reset);
    // The device synchronises select, so it reacts up to three edges late.
    sequence s_held;
        $fell(cs_n) ##1 !cs_n [*2];
    endsequence
    AST_START: assert property (s_held |=> sd_first_oe)
        else $error("outputs not enabled");
    AST_RELEASE: assert property ($rose(cs_n) |-> ##[1:3] !sd_first_oe)
        else $error("no release after select rise");
    AST_IDLE: assert property (cs_n [*4] |-> !sd_first_oe)
        else $error("driving while deselected");
    AST_GAP: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("select fell too soon");
    AST_MAX32: assert property (sd_first_oe |-> run < 6'h20)
        else $error("driven past bit 31");
    AST_HOLD: assert property (sd_first_oe && !cs_n && run < 6'h1F |=> sd_first_oe)
        else $error("released while selected");
    AST_ZERO: assert property (sd_first_oe && run inside {6'h00, 6'h01, 6'h10, 6'h11} |-> !sd_first && !sd_second)
        else $error("framing bit not zero");
    AST_PAIR: assert property (sd_first_oe == sd_second_oe)
        else $error("lines enabled apart");
endmodule

// ### tb_top.sv
// Self-checking bench joining the converter end and the host end.
`timescale 1ns/10ps
module tb_top;
    localparam logic [13:0] A = 14'h2a5c;
    localparam logic [13:0] B = 14'h1c63;
    logic                clk = 1'b0;
    logic                reset = 1'b1;
    logic                cmd_valid = 1'b0;
    logic                cmd_long_wait = 1'b0;
    logic [5:0]          cmd_edges = 6'h00;
    logic [13:0]         sample_first = A;
    logic [13:0]         sample_second = B;
    logic                rsp_valid;
    logic [31:0]         rsp_first;
    logic [31:0]         rsp_second;
    apm_pkg::apm_power_t power_state;
    logic                ref_on;
    logic                analog_on;
    logic                conv_done;
    logic                analog_ready;
    logic                th_hold;
    logic                cmd_ready;
    int                  failures = 0;
    int                  n_checks = 0;
    int                  cycles = 0;
    int                  n_conv = 0;
    // ==================================================
    always #25 clk = ~clk;
    apm_link_if link ();
    apm_dev_end apm_dev_end_inst (.link(link.dev), .reset(reset), .clk_en(1'b1), .sample_first(sample_first),
        .sample_second(sample_second), .power_state(power_state), .ref_on(ref_on), .analog_on(analog_on),
        .analog_ready(analog_ready), .th_hold(th_hold), .conv_done(conv_done));
    apm_host_end #(.WAKE_CYCLES(50)) apm_host_end_inst (.link(link.host), .clk(clk), .reset(reset), .clk_en(1'b1),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_edges(cmd_edges), .cmd_long_wait(cmd_long_wait),
        .rsp_valid(rsp_valid), .rsp_first(rsp_first), .rsp_second(rsp_second));
    apm_link_sva apm_link_sva_inst (.sclk(link.sclk), .reset(reset), .cs_n(link.cs_n), .sd_first(link.sd_first),
        .sd_first_oe(link.sd_first_oe), .sd_second(link.sd_second), .sd_second_oe(link.sd_second_oe));
    always @(negedge link.sclk) if (conv_done === 1'b1) n_conv++;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic frame(input logic [5:0] edges, input logic long_wait);
        int i;
        cmd_edges = edges;
        cmd_long_wait = long_wait;
        cmd_valid = 1'b1;
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        check({31'h0, cmd_ready}, 32'h0);
        for (i = 0; i < 2000 && rsp_valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check({30'h0, rsp_valid, cmd_ready}, 32'h3);
    endtask
    // The host takes each bit in the window after a falling edge, so reading all 32 bits needs 35 edges.
    task automatic t_dual();
        frame(6'h23, 1'b0);
        frame(6'h23, 1'b0);
        check(rsp_first, {2'b00, A, 2'b00, B});
        check(rsp_second, {2'b00, B, 2'b00, A});
    endtask
    task automatic t_abort();
        int c;
        c = n_conv;
        sample_first = ~A;
        frame(6'h0c, 1'b0);
        check(32'(n_conv - c), 32'h0);
        check({30'h0, power_state}, 32'h0);
        frame(6'h23, 1'b0);
        check(rsp_first, {2'b00, A, 2'b00, B});
        check(32'(n_conv - c), 32'h1);
    endtask
    // Glitch, partial, glitch, full, full, wake with the long wait, glitch.
    task automatic t_modes();
        int i;
        logic [5:0] e [7] = '{6'h01, 6'h05, 6'h01, 6'h05, 6'h05, 6'h0c, 6'h01};
        logic [1:0] s [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
        for (i = 0; i < 7; i++) begin
            frame(e[i], i == 5);
            check({30'h0, power_state}, {30'h0, s[i]});
            check({30'h0, ref_on, analog_on}, {30'h0, s[i] != 2'h2, s[i] == 2'h0});
            check({30'h0, analog_ready, th_hold}, {30'h0, s[i] == 2'h0, s[i] != 2'h0});
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        t_dual();
        t_abort();
        t_modes();
        print_verdict();
    end
endmodule
